// file: sbr_pkg.sv
// Shared constants and types for the split-bank row-cycle timing block
package sbr_pkg;
  // ---------------------------------------------------------------
  // Clock and geometry
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int NUM_BANKS        = 32;
  localparam int BANK_W           = 5;
  localparam int DEV_W            = 5;
  localparam int ROW_W            = 9;
  localparam int COL_W            = 6;
  localparam int LOWER_TOP_BANK   = 15;
  localparam int UPPER_LOW_BANK   = 16;
  localparam int AMP_BYTES        = 512;
  localparam int LANE_BYTES       = 256;
  // ---------------------------------------------------------------
  // Times in ns and derived cycle counts
  // ---------------------------------------------------------------
  localparam int ROW_TO_COLUMN_DELAY_NS   = 20;
  localparam int ROW_ACTIVE_TIME_NS       = 40;
  localparam int PRECHARGE_TIME_NS        = 20;
  localparam int COLUMN_READ_LATENCY_NS   = 20;
  localparam int AUTO_PRECHARGE_OFFSET_NS = 30;
  localparam int RETIRE_DELAY_NS          = 20;
  // Least times round up
  localparam int RCD_CYC  = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_CYC  = (ROW_ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC   = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAC_CYC  = (COLUMN_READ_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFFP_CYC = (AUTO_PRECHARGE_OFFSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RTR_CYC  = (RETIRE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REST_CYC = RAS_CYC - RCD_CYC;
  localparam int CNT_W    = 8;
  // ---------------------------------------------------------------
  // Column operation codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    COL_NOP       = 3'h0,
    COL_READ      = 3'h1,
    COL_STORE     = 3'h2,
    COL_READ_AC   = 3'h3,
    COL_STORE_AC  = 3'h4
  } sbr_col_op_e;
  // Bank row-cycle phases
  typedef enum logic [4:0] {
    BK_IDLE  = 5'h01,
    BK_ACT   = 5'h02,
    BK_REST  = 5'h04,
    BK_OPEN  = 5'h08,
    BK_PRE   = 5'h10
  } sbr_bank_e;
endpackage

// file: sbr_bank.sv
// One bank's activate, restore, column window and precharge sequencer
`timescale 1ns/10ps
`default_nettype none
module sbr_bank (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic open_req,
  input  wire logic close_req,
  output logic      busy,
  output logic      col_ok,
  output logic      restoring
);
  sbr_pkg::sbr_bank_e             st_r;
  sbr_pkg::sbr_bank_e             st_nxt;
  logic [sbr_pkg::CNT_W-1:0]      cnt_r;
  logic [sbr_pkg::CNT_W-1:0]      cnt_nxt;
  logic                           pend_r;
  logic                           pend_nxt;
  wire                            cnt_done = (cnt_r == '0);

  assign busy      = (st_r != sbr_pkg::BK_IDLE);
  assign col_ok    = (st_r == sbr_pkg::BK_REST) || (st_r == sbr_pkg::BK_OPEN);
  assign restoring = (st_r == sbr_pkg::BK_ACT) || (st_r == sbr_pkg::BK_REST);

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_done ? cnt_r : cnt_r - 1'b1;
    // A close seen early is held until restore has finished
    pend_nxt = pend_r | close_req;
    unique case (st_r)
      sbr_pkg::BK_IDLE: begin
        pend_nxt = 1'b0;
        if (open_req) begin
          st_nxt  = sbr_pkg::BK_ACT;
          cnt_nxt = sbr_pkg::CNT_W'(sbr_pkg::RCD_CYC - 1);
        end
      end
      sbr_pkg::BK_ACT: begin
        if (cnt_done) begin
          st_nxt  = sbr_pkg::BK_REST;
          cnt_nxt = sbr_pkg::CNT_W'(sbr_pkg::REST_CYC - 1);
        end
      end
      sbr_pkg::BK_REST: begin
        if (cnt_done) begin
          st_nxt = sbr_pkg::BK_OPEN;
        end
      end
      sbr_pkg::BK_OPEN: begin
        if (pend_r || close_req) begin
          st_nxt   = sbr_pkg::BK_PRE;
          pend_nxt = 1'b0;
          cnt_nxt  = sbr_pkg::CNT_W'(sbr_pkg::RP_CYC - 1);
        end
      end
      sbr_pkg::BK_PRE: begin
        pend_nxt = 1'b0;
        if (cnt_done) begin
          st_nxt = sbr_pkg::BK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= sbr_pkg::BK_IDLE;
      cnt_r  <= '0;
      pend_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      pend_r <= pend_nxt;
    end
  end
endmodule
`default_nettype wire

// file: sbr_core.sv
// Split-bank row-cycle timing core: packet decode, banks, retire and read return
//
// Contract
// - Device restores sensed row automatically after activation, no command needed.
// - Stored sense amp data is forwarded to the open row's cells.
// - Activate, restore and precharge take their minimum intervals.
// - Sense amps are shared by neighbours except amps 0, 15, 16, 31.
// - Opening a bank claims both amps; neighbours must stay closed meanwhile.
// - Each amp loads 512 bytes: 256 per lane A, 256 per lane B.
// - Read-autoclose precharges like a close placed offset after its packet.
// - Store-autoclose precharges offset after the packet causing its retire.
// - Retire happens on the packet retire delay after store unless self-read.
// - Extended close precharges the bank offset after the extended packet; code drops it when another bank's store-autoclose retires that cycle.
// - Read allowed after row-to-column delay; data returns column latency later.
// - Command timing references packet end; data packets reference their start.
// - Open carries device, bank, row; read carries device, bank, column.
// - Missed retire waits for first framed packet that is not a self-read.
`timescale 1ns/10ps
`default_nettype none
module sbr_core #(
  parameter int NUM_BANKS = sbr_pkg::NUM_BANKS
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic [sbr_pkg::DEV_W-1:0]   dev_id,
  input  wire logic                        row_pkt_valid,
  input  wire logic                        row_pkt_open,
  input  wire logic [sbr_pkg::DEV_W-1:0]   row_dev,
  input  wire logic [sbr_pkg::BANK_W-1:0]  row_bank,
  input  wire logic [sbr_pkg::ROW_W-1:0]   row_addr,
  input  wire logic                        col_pkt_valid,
  input  wire logic [2:0]                  col_op,
  input  wire logic [sbr_pkg::DEV_W-1:0]   col_dev,
  input  wire logic [sbr_pkg::BANK_W-1:0]  col_bank,
  input  wire logic [sbr_pkg::COL_W-1:0]   col_addr,
  input  wire logic                        ext_pkt_valid,
  input  wire logic                        ext_close,
  input  wire logic [sbr_pkg::DEV_W-1:0]   ext_dev,
  input  wire logic [sbr_pkg::BANK_W-1:0]  ext_bank,
  output logic [NUM_BANKS-1:0]             bank_open_r,
  output logic [NUM_BANKS-1:0]             restore_busy_r,
  output logic                             adj_conflict_r,
  output logic                             rd_data_valid_r,
  output logic [sbr_pkg::BANK_W-1:0]       rd_data_bank_r,
  output logic [sbr_pkg::ROW_W-1:0]        rd_data_row_r,
  output logic [sbr_pkg::COL_W-1:0]        rd_data_col_r,
  output logic                             cell_write_r,
  output logic [sbr_pkg::BANK_W-1:0]       cell_write_bank_r,
  output logic [sbr_pkg::ROW_W-1:0]        cell_write_row_r,
  output logic [sbr_pkg::COL_W-1:0]        cell_write_col_r
);
  // ---------------------------------------------------------------
  // Packet decode
  // ---------------------------------------------------------------
  localparam int OFFP = sbr_pkg::OFFP_CYC;
  localparam int CAC  = sbr_pkg::CAC_CYC;

  sbr_pkg::sbr_col_op_e op;
  assign op = sbr_pkg::sbr_col_op_e'(col_op);

  logic [NUM_BANKS-1:0]          busy;
  logic [NUM_BANKS-1:0]          col_ok;
  logic [NUM_BANKS-1:0]          restoring;
  logic [NUM_BANKS-1:0]          open_vec;
  logic [NUM_BANKS-1:0]          close_vec;
  logic [NUM_BANKS-1:0]          nbr_busy;
  logic [sbr_pkg::ROW_W-1:0]     row_of [NUM_BANKS];

  wire row_me   = row_pkt_valid && (row_dev == dev_id);
  wire col_me   = col_pkt_valid && (col_dev == dev_id);
  wire is_read  = (op == sbr_pkg::COL_READ) || (op == sbr_pkg::COL_READ_AC);
  wire is_store = (op == sbr_pkg::COL_STORE) || (op == sbr_pkg::COL_STORE_AC);
  wire self_rd  = col_me && is_read;
  wire rd_go    = self_rd && col_ok[col_bank];
  wire st_go    = col_me && is_store && col_ok[col_bank];
  wire ext_go   = ext_pkt_valid && ext_close && (ext_dev == dev_id);

  // ---------------------------------------------------------------
  // Write buffer and retire
  // ---------------------------------------------------------------
  logic                          wb_full_r;
  logic                          wb_ac_r;
  logic [sbr_pkg::BANK_W-1:0]    wb_bank_r;
  logic [sbr_pkg::COL_W-1:0]     wb_col_r;
  logic [sbr_pkg::CNT_W-1:0]     wb_cnt_r;

  wire wb_due    = wb_full_r && (wb_cnt_r == '0);
  wire retire_go = wb_due && col_pkt_valid && !self_rd;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_full_r <= 1'b0;
      wb_ac_r   <= 1'b0;
      wb_bank_r <= '0;
      wb_col_r  <= '0;
      wb_cnt_r  <= '0;
    end else if (st_go) begin
      wb_full_r <= 1'b1;
      wb_ac_r   <= (op == sbr_pkg::COL_STORE_AC);
      wb_bank_r <= col_bank;
      wb_col_r  <= col_addr;
      wb_cnt_r  <= sbr_pkg::CNT_W'(sbr_pkg::RTR_CYC - 1);
    end else if (retire_go) begin
      wb_full_r <= 1'b0;
    end else if (wb_full_r && wb_cnt_r != '0) begin
      wb_cnt_r <= wb_cnt_r - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Offset close pipeline, shared by all three auto mechanisms
  // ---------------------------------------------------------------
  // read-autoclose, store-autoclose on retire, extended
  wire                        ac_in_v = (col_me && op == sbr_pkg::COL_READ_AC) || ext_go
                                        || (retire_go && wb_ac_r);
  wire [sbr_pkg::BANK_W-1:0]  ac_in_b = (retire_go && wb_ac_r) ? wb_bank_r
                                      : (ext_go ? ext_bank : col_bank);
  logic                       ac_v_r [OFFP];
  logic [sbr_pkg::BANK_W-1:0] ac_b_r [OFFP];
  // Read return pipeline
  logic                       rq_v_r [CAC];
  logic [sbr_pkg::BANK_W-1:0] rq_b_r [CAC];
  logic [sbr_pkg::COL_W-1:0]  rq_c_r [CAC];

  // Same-cycle ext close and autoclose read on different banks: the extended one wins,
  // the read-autoclose bank still closes through the ac2 pipeline below.
  wire both_ac = ext_go && col_me && (op == sbr_pkg::COL_READ_AC) && (ext_bank != col_bank);

  genvar gi;
  generate
    for (gi = 0; gi < OFFP; gi++) begin : g_ac
      // Stage zero reads itself so no index falls below the array
      localparam int PREV_IDX = (gi == 0) ? 0 : gi - 1;
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ac_v_r[gi] <= 1'b0;
          ac_b_r[gi] <= '0;
        end else begin
          ac_v_r[gi] <= (gi == 0) ? ac_in_v : ac_v_r[PREV_IDX];
          ac_b_r[gi] <= (gi == 0) ? ac_in_b : ac_b_r[PREV_IDX];
        end
      end
    end
    for (gi = 0; gi < CAC; gi++) begin : g_rq
      localparam int PREV_IDX = (gi == 0) ? 0 : gi - 1;
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          rq_v_r[gi] <= 1'b0;
          rq_b_r[gi] <= '0;
          rq_c_r[gi] <= '0;
        end else begin
          rq_v_r[gi] <= (gi == 0) ? rd_go : rq_v_r[PREV_IDX];
          rq_b_r[gi] <= (gi == 0) ? col_bank : rq_b_r[PREV_IDX];
          rq_c_r[gi] <= (gi == 0) ? col_addr : rq_c_r[PREV_IDX];
        end
      end
    end
  endgenerate

  logic                       ac2_v_r [OFFP];
  logic [sbr_pkg::BANK_W-1:0] ac2_b_r [OFFP];
  generate
    for (gi = 0; gi < OFFP; gi++) begin : g_ac2
      localparam int PREV_IDX = (gi == 0) ? 0 : gi - 1;
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ac2_v_r[gi] <= 1'b0;
          ac2_b_r[gi] <= '0;
        end else begin
          ac2_v_r[gi] <= (gi == 0) ? both_ac : ac2_v_r[PREV_IDX];
          ac2_b_r[gi] <= (gi == 0) ? col_bank : ac2_b_r[PREV_IDX];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Banks
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
      localparam bit HAS_LO = (gi != 0) && (gi != sbr_pkg::UPPER_LOW_BANK);
      localparam bit HAS_HI = (gi != NUM_BANKS - 1) && (gi != sbr_pkg::LOWER_TOP_BANK);
      assign nbr_busy[gi]  = (HAS_LO ? busy[(gi == 0) ? 0 : gi - 1] : 1'b0)
                           | (HAS_HI ? busy[(gi == NUM_BANKS - 1) ? gi : gi + 1] : 1'b0);
      // neighbour must be closed to open
      assign open_vec[gi]  = row_me && row_pkt_open && (row_bank == gi) && !nbr_busy[gi];
      assign close_vec[gi] = (row_me && !row_pkt_open && row_bank == gi)
                           | (ac_v_r[OFFP-1] && ac_b_r[OFFP-1] == gi)
                           | (ac2_v_r[OFFP-1] && ac2_b_r[OFFP-1] == gi);
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          row_of[gi] <= '0;
        end else if (open_vec[gi] && !busy[gi]) begin
          row_of[gi] <= row_addr;
        end
      end
      sbr_bank u_bank (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .open_req  (open_vec[gi]),
        .close_req (close_vec[gi]),
        .busy      (busy[gi]),
        .col_ok    (col_ok[gi]),
        .restoring (restoring[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  wire adj_bad = row_me && row_pkt_open && nbr_busy[row_bank];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank_open_r       <= '0;
      restore_busy_r    <= '0;
      adj_conflict_r    <= 1'b0;
      rd_data_valid_r   <= 1'b0;
      rd_data_bank_r    <= '0;
      rd_data_row_r     <= '0;
      rd_data_col_r     <= '0;
      cell_write_r      <= 1'b0;
      cell_write_bank_r <= '0;
      cell_write_row_r  <= '0;
      cell_write_col_r  <= '0;
    end else begin
      bank_open_r       <= busy;
      restore_busy_r    <= restoring;
      adj_conflict_r    <= adj_bad;
      rd_data_valid_r   <= rq_v_r[CAC-1];
      rd_data_bank_r    <= rq_b_r[CAC-1];
      rd_data_row_r     <= row_of[rq_b_r[CAC-1]];
      rd_data_col_r     <= rq_c_r[CAC-1];
      // retired store forwarded to open row
      cell_write_r      <= retire_go;
      cell_write_bank_r <= wb_bank_r;
      cell_write_row_r  <= row_of[wb_bank_r];
      cell_write_col_r  <= wb_col_r;
    end
  end
endmodule
`default_nettype wire

// file: sbr_core_checker.sv
// Concurrent checks on the ports of the split-bank row-cycle timing core
`timescale 1ns/10ps
`default_nettype none
module sbr_core_checker #(
  parameter int NUM_BANKS = 32
) (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic [4:0]           dev_id,
  input wire logic                 row_pkt_valid,
  input wire logic                 row_pkt_open,
  input wire logic [4:0]           row_dev,
  input wire logic [4:0]           row_bank,
  input wire logic                 col_pkt_valid,
  input wire logic [2:0]           col_op,
  input wire logic [4:0]           col_dev,
  input wire logic [5:0]           col_addr,
  input wire logic                 ext_pkt_valid,
  input wire logic                 ext_close,
  input wire logic [4:0]           ext_dev,
  input wire logic [4:0]           ext_bank,
  input wire logic [NUM_BANKS-1:0] bank_open_r,
  input wire logic [NUM_BANKS-1:0] restore_busy_r,
  input wire logic                 adj_conflict_r,
  input wire logic                 rd_data_valid_r,
  input wire logic [5:0]           rd_data_col_r,
  input wire logic                 cell_write_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire self_row = row_pkt_valid && row_dev == dev_id;
  wire self_rd  = col_dev == dev_id && (col_op == 3'h1 || col_op == 3'h3);
  // ---------------------------------------------------------------
  // Row cycle phases
  // ---------------------------------------------------------------
  open_rise_a:
    assert property (self_row && row_pkt_open && bank_open_r == '0
      |-> ##2 bank_open_r[$past(row_bank, 2)] && restore_busy_r[$past(row_bank, 2)]) else $error("open not seen");
  restore_len_a:
    assert property ($rose(restore_busy_r[3]) |-> restore_busy_r[3][*4] ##1 !restore_busy_r[3]) else $error("restore span");
  close_pre_a:
    assert property (self_row && !row_pkt_open && row_bank == 5'h03 && bank_open_r[3] && !restore_busy_r[3]
      |-> bank_open_r[3][*4] ##1 !bank_open_r[3]) else $error("precharge span");
  auto_close_a:
    assert property (ext_pkt_valid && ext_close && ext_dev == dev_id && ext_bank == 5'h03 && bank_open_r[3]
      && !restore_busy_r[3] |-> bank_open_r[3][*7] ##1 !bank_open_r[3]) else $error("extended close timing");
  // ---------------------------------------------------------------
  // Column path and shared amps
  // ---------------------------------------------------------------
  rd_return_a:
    assert property (rd_data_valid_r |-> $past(col_pkt_valid, 3) && $past(col_dev, 3) == dev_id
      && rd_data_col_r == $past(col_addr, 3)) else $error("read return slot");
  retire_slot_a:
    assert property (cell_write_r |-> $past(col_pkt_valid) && !$past(self_rd)) else $error("retire packet");
  retire_wait_a:
    assert property (col_pkt_valid && col_dev == dev_id && col_op == 3'h2 |-> ##2 !cell_write_r) else $error("early retire");
  adj_block_a:
    assert property (self_row && row_pkt_open && row_bank == 5'h04 && restore_busy_r[3]
      |=> adj_conflict_r ##1 !bank_open_r[4]) else $error("neighbour open not refused");
  split_edge_a:
    assert property (self_row && row_pkt_open && row_bank == 5'h10 && restore_busy_r[15] && !bank_open_r[17]
      && !bank_open_r[16] |=> !adj_conflict_r ##1 bank_open_r[16]) else $error("unshared edge refused");
  cover property (adj_conflict_r);
  cover property (cell_write_r);
  cover property (rd_data_valid_r ##1 rd_data_valid_r);
endmodule
bind sbr_core sbr_core_checker #(.NUM_BANKS(NUM_BANKS)) u_chk (.mclk, .rst_n, .dev_id, .row_pkt_valid, .row_pkt_open,
  .row_dev, .row_bank, .col_pkt_valid, .col_op, .col_dev, .col_addr, .ext_pkt_valid, .ext_close, .ext_dev, .ext_bank,
  .bank_open_r, .restore_busy_r, .adj_conflict_r, .rd_data_valid_r, .rd_data_col_r, .cell_write_r);
`default_nettype wire

// file: sbr_ctrl_model.sv
// Controller model that frames row, column and extended packets
`timescale 1ns/10ps
`default_nettype none
module sbr_ctrl_model (
  input  wire logic  mclk,
  output logic       row_pkt_valid,
  output logic       row_pkt_open,
  output logic [4:0] row_dev,
  output logic [4:0] row_bank,
  output logic [8:0] row_addr,
  output logic       col_pkt_valid,
  output logic [2:0] col_op,
  output logic [4:0] col_dev,
  output logic [4:0] col_bank,
  output logic [5:0] col_addr,
  output logic       ext_pkt_valid,
  output logic       ext_close,
  output logic [4:0] ext_dev,
  output logic [4:0] ext_bank
);
  initial begin
    {row_pkt_valid, row_pkt_open, row_dev, row_bank, row_addr} = '0;
    {col_pkt_valid, col_op, col_dev, col_bank, col_addr} = '0;
    {ext_pkt_valid, ext_close, ext_dev, ext_bank} = '0;
  end
  // packet end edge
  // Released fields are inverted so a stale value is never mistaken for a live one
  task automatic row_cmd(input logic op, input logic [4:0] dv, bk, input logic [8:0] ra, input logic hold);
    {row_pkt_valid, row_pkt_open, row_dev, row_bank, row_addr} = {1'b1, op, dv, bk, ra};
    @(negedge mclk);
    if (!hold) begin
      row_pkt_valid = 1'b0;
      {row_pkt_open, row_dev, row_bank, row_addr} = ~{row_pkt_open, row_dev, row_bank, row_addr};
    end
  endtask
  task automatic col_cmd(input logic [2:0] op, input logic [4:0] dv, bk, input logic [5:0] ca, input logic hold);
    {col_pkt_valid, col_op, col_dev, col_bank, col_addr} = {1'b1, op, dv, bk, ca};
    @(negedge mclk);
    if (!hold) begin
      col_pkt_valid = 1'b0;
      {col_op, col_dev, col_bank, col_addr} = ~{col_op, col_dev, col_bank, col_addr};
    end
  endtask
  task automatic ext_cmd(input logic [4:0] dv, bk);
    {ext_pkt_valid, ext_close, ext_dev, ext_bank} = {2'b11, dv, bk};
    @(negedge mclk);
    ext_pkt_valid = 1'b0;
    {ext_close, ext_dev, ext_bank} = ~{ext_close, ext_dev, ext_bank};
  endtask
endmodule
`default_nettype wire

// file: split_bank_row_cycle_timing_test.sv
// Self-checking bench for the split-bank row-cycle timing core
`timescale 1ns/10ps
`default_nettype none
module split_bank_row_cycle_timing_test;
  localparam logic [4:0] DEV = 5'h07;
  logic mclk = 1'b0;
  logic rst_n, row_pkt_valid, row_pkt_open, col_pkt_valid, ext_pkt_valid, ext_close;
  logic [4:0] dev_id, row_dev, row_bank, col_dev, col_bank, ext_dev, ext_bank, rd_data_bank_r, cell_write_bank_r;
  logic [8:0] row_addr, rd_data_row_r, cell_write_row_r;
  logic [5:0] col_addr, rd_data_col_r, cell_write_col_r;
  logic [2:0] col_op;
  logic [31:0] bank_open_r, restore_busy_r;
  logic adj_conflict_r, rd_data_valid_r, cell_write_r;
  int err_count = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  sbr_ctrl_model u_ctl (.mclk, .row_pkt_valid, .row_pkt_open, .row_dev, .row_bank, .row_addr, .col_pkt_valid,
    .col_op, .col_dev, .col_bank, .col_addr, .ext_pkt_valid, .ext_close, .ext_dev, .ext_bank);
  sbr_core DUT (.mclk, .rst_n, .dev_id, .row_pkt_valid, .row_pkt_open, .row_dev, .row_bank, .row_addr,
    .col_pkt_valid, .col_op, .col_dev, .col_bank, .col_addr, .ext_pkt_valid, .ext_close, .ext_dev, .ext_bank,
    .bank_open_r, .restore_busy_r, .adj_conflict_r, .rd_data_valid_r, .rd_data_bank_r, .rd_data_row_r,
    .rd_data_col_r, .cell_write_r, .cell_write_bank_r, .cell_write_row_r, .cell_write_col_r);
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_read;
    u_ctl.row_cmd(1'b1, DEV, 5'h03, 9'h1A5, 1'b0);
    w(2);
    u_ctl.col_cmd(3'h1, DEV, 5'h03, 6'h05, 1'b1);
    u_ctl.col_cmd(3'h1, DEV, 5'h03, 6'h06, 1'b0);
    w(1);
    chk({rd_data_valid_r, rd_data_bank_r, rd_data_row_r, rd_data_col_r}, {1'b1, 5'h03, 9'h1A5, 6'h05});
    w(1);
    chk({rd_data_valid_r, rd_data_col_r}, {1'b1, 6'h06});
    u_ctl.row_cmd(1'b0, DEV, 5'h03, 9'h000, 1'b0);
    w(2);
    chk(bank_open_r[3], 1'b1);
    w(1);
    chk(bank_open_r[3], 1'b0);
    w(2);
    $display("read test done");
  endtask
  task automatic t_adj;
    u_ctl.row_cmd(1'b1, DEV, 5'h03, 9'h011, 1'b0);
    w(2);
    u_ctl.row_cmd(1'b1, DEV, 5'h04, 9'h022, 1'b0);
    chk(adj_conflict_r, 1'b1);
    w(1);
    chk(bank_open_r[4], 1'b0);
    u_ctl.row_cmd(1'b1, DEV, 5'h0F, 9'h033, 1'b0);
    w(2);
    u_ctl.row_cmd(1'b1, DEV, 5'h10, 9'h044, 1'b0);
    chk(adj_conflict_r, 1'b0);
    w(1);
    chk(bank_open_r[16], 1'b1);
    u_ctl.row_cmd(1'b1, 5'h08, 5'h0A, 9'h055, 1'b0);
    w(2);
    chk(bank_open_r[10], 1'b0);
    u_ctl.row_cmd(1'b0, DEV, 5'h03, 9'h000, 1'b0);
    w(1);
    u_ctl.row_cmd(1'b0, DEV, 5'h0F, 9'h000, 1'b0);
    w(1);
    u_ctl.row_cmd(1'b0, DEV, 5'h10, 9'h000, 1'b0);
    w(8);
    $display("adjacency test done");
  endtask
  task automatic t_store;
    u_ctl.row_cmd(1'b1, DEV, 5'h03, 9'h0F0, 1'b0);
    w(2);
    u_ctl.col_cmd(3'h2, DEV, 5'h03, 6'h09, 1'b0);
    w(1);
    u_ctl.col_cmd(3'h0, 5'h1F, 5'h00, 6'h00, 1'b0);
    chk({cell_write_r, cell_write_bank_r, cell_write_row_r, cell_write_col_r}, {1'b1, 5'h03, 9'h0F0, 6'h09});
    u_ctl.col_cmd(3'h2, DEV, 5'h03, 6'h0A, 1'b0);
    w(1);
    u_ctl.col_cmd(3'h1, DEV, 5'h03, 6'h01, 1'b1);
    chk(cell_write_r, 1'b0);
    u_ctl.col_cmd(3'h0, 5'h1F, 5'h00, 6'h00, 1'b0);
    chk({cell_write_r, cell_write_col_r}, {1'b1, 6'h0A});
    u_ctl.row_cmd(1'b0, DEV, 5'h03, 9'h000, 1'b0);
    w(8);
    $display("store test done");
  endtask
  task automatic t_auto;
    for (int k = 0; k < 3; k++) begin
      u_ctl.row_cmd(1'b1, DEV, 5'h03, 9'(k), 1'b0);
      w(6);
      case (k)
        0: u_ctl.col_cmd(3'h3, DEV, 5'h03, 6'h02, 1'b0);
        1: u_ctl.ext_cmd(DEV, 5'h03);
        default: begin
          u_ctl.col_cmd(3'h4, DEV, 5'h03, 6'h03, 1'b0);
          w(1);
          u_ctl.col_cmd(3'h0, DEV, 5'h03, 6'h00, 1'b0);
        end
      endcase
      w(5);
      chk(bank_open_r[3], 1'b1);
      w(1);
      chk(bank_open_r[3], 1'b0);
      w(3);
    end
    $display("auto close test done");
  endtask
  initial begin
    rst_n = 1'b0;
    dev_id = DEV;
    w(20);
    rst_n = 1'b1;
    w(2);
    t_read;
    t_adj;
    t_store;
    t_auto;
    test_done;
  end
  // Tests need about 150 cycles; cut a hang at 2000
  initial begin
    #20_000;
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire
